// file: hw/awc_compare.sv
// Combinational window decision on one justified result word
`timescale 1ns/1ps
`default_nettype none
module awc_compare (
    awc_cmp_if.cmp c
);
    // Signed order becomes unsigned order once the sign bit is flipped
    function automatic logic [16:0] awc_key(input logic [15:0] v,
                                            input logic sgn);
        awc_key = {1'b0, v[15] ^ sgn, v[14:0]};
    endfunction

    logic [16:0] k_w;
    logic [16:0] k_gt;
    logic [16:0] k_lt;
    always_comb begin
        k_w = awc_key(c.word, c.is_signed);
        k_gt = awc_key(c.gt_lim, c.is_signed);
        k_lt = awc_key(c.lt_lim, c.is_signed);
        if (k_lt > k_gt) begin
            c.hit = (k_w > k_gt) && (k_w < k_lt);
        end else begin
            c.hit = (k_w < k_gt) || (k_w > k_lt);
        end
    end
endmodule
`default_nettype wire

// file: hw/awc_top.sv
// Converter window comparator: conversion timing, result format, flag
// Behaviour
// - Single-ended result is unsigned ten bits
// - Differential result is ten-bit two's complement
// - Inside window: strictly between both limits
// - Outside window: below greater or above less
// - Differential compares use signed ordering
// - Left-justified words compare against justified limits
// - Conversion takes at least ten SAR clocks
// - Window sense chosen by limit order, signed when differential
// - Every result is compared; flag notifies
`timescale 1ns/1ps
`default_nettype none
module awc_top #(
    parameter int SAR_DIV = awc_pkg::SAR_DIV,
    parameter int CONV_CLKS = awc_pkg::CONV_SAR_CLKS
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic conv_start,
    input wire logic [9:0] sample_code,
    input wire logic differential,
    input wire logic left_justify,
    input wire logic [7:0] upper_bound_compare_high,
    input wire logic [7:0] upper_bound_compare_low,
    input wire logic [7:0] lower_bound_compare_high,
    input wire logic [7:0] lower_bound_compare_low,
    input wire logic flag_clear,
    output logic [7:0] conversion_result_high,
    output logic [7:0] conversion_result_low,
    output logic conv_busy,
    output logic conv_done,
    output logic window_match_flag
);
    typedef struct packed {
        awc_pkg::awc_state_e st;
        logic [7:0] div;
        logic [7:0] bits;
        logic [9:0] code;
        logic [15:0] result;
        logic done;
        logic flag;
    } awc_s;

    awc_s r_ff;
    awc_s nxt_r;
    logic sar_tick;
    logic [15:0] fmt_word;

    awc_cmp_if cif ();
    awc_compare u_cmp (
        .c(cif.cmp)
    );

    // Place a code in the 16-bit result word per justification and sign
    function automatic logic [15:0] awc_fmt(input logic [9:0] code,
                                            input logic sgn,
                                            input logic lj);
        if (lj) begin
            awc_fmt = {code, 6'h00};
        end else if (sgn) begin
            awc_fmt = {{6{code[9]}}, code};
        end else begin
            awc_fmt = {6'h00, code};
        end
    endfunction

    assign sar_tick = (r_ff.div == 8'(SAR_DIV - 1));
    assign fmt_word = awc_fmt(r_ff.code, differential, left_justify);
    assign cif.word = fmt_word;
    assign cif.gt_lim = {upper_bound_compare_high, upper_bound_compare_low};
    assign cif.lt_lim = {lower_bound_compare_high, lower_bound_compare_low};
    assign cif.is_signed = differential;

    always_comb begin
        nxt_r = r_ff;
        nxt_r.done = 1'b0;
        nxt_r.div = sar_tick ? 8'h00 : r_ff.div + 8'h01;
        // A clear in the same cycle as a hit loses: the event is kept
        if (flag_clear) begin
            nxt_r.flag = 1'b0;
        end
        unique case (r_ff.st)
            awc_pkg::AWC_IDLE: begin
                if (conv_start) begin
                    nxt_r.st = awc_pkg::AWC_CONV;
                    nxt_r.bits = 8'h00;
                    nxt_r.div = 8'h00;
                    nxt_r.code = sample_code;
                end
            end
            awc_pkg::AWC_CONV: begin
                if (sar_tick) begin
                    nxt_r.bits = r_ff.bits + 8'h01;
                    if (r_ff.bits == 8'(CONV_CLKS - 1)) begin
                        nxt_r.st = awc_pkg::AWC_DONE;
                    end
                end
            end
            awc_pkg::AWC_DONE: begin
                nxt_r.result = fmt_word;
                nxt_r.done = 1'b1;
                nxt_r.st = awc_pkg::AWC_IDLE;
                if (cif.hit) begin
                    nxt_r.flag = 1'b1;
                end
            end
            default: begin
                nxt_r.st = awc_pkg::AWC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            r_ff <= '{st: awc_pkg::AWC_IDLE, div: 8'h00, bits: 8'h00,
                code: 10'h000, result: awc_pkg::RESULT_RST,
                done: 1'b0, flag: 1'b0};
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign conversion_result_high = r_ff.result[15:8];
    assign conversion_result_low = r_ff.result[7:0];
    assign conv_busy = (r_ff.st != awc_pkg::AWC_IDLE);
    assign conv_done = r_ff.done;
    assign window_match_flag = r_ff.flag;

    // Assertions
    int unsigned conv_cnt_ff;
    always_ff @(posedge clk_sys) begin
        if (srst || r_ff.st == awc_pkg::AWC_IDLE) begin
            conv_cnt_ff <= 0;
        end else begin
            conv_cnt_ff <= conv_cnt_ff + 1;
        end
    end

    sequence s_done_hit;
        conv_done && $past(cif.hit);
    endsequence

    property p_conv_len;
        @(posedge clk_sys) disable iff (srst)
        $rose(conv_done) |-> $past(conv_cnt_ff) >= SAR_DIV * CONV_CLKS;
    endproperty
    a_conv_len: assert property (p_conv_len)
        else $error("conversion finished too early");

    property p_flag_set;
        @(posedge clk_sys) disable iff (srst)
        s_done_hit |-> window_match_flag;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("hit did not set flag");

    property p_flag_sticky;
        @(posedge clk_sys) disable iff (srst)
        window_match_flag && !flag_clear |=> window_match_flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("flag dropped without clear");

    property p_flag_cause;
        @(posedge clk_sys) disable iff (srst)
        $rose(window_match_flag) |-> conv_done;
    endproperty
    a_flag_cause: assert property (p_flag_cause)
        else $error("flag rose without a result");

    property p_inside;
        @(posedge clk_sys) disable iff (srst)
        (cif.lt_lim > cif.gt_lim) && !differential
        && (cif.word > cif.gt_lim) && (cif.word < cif.lt_lim) |-> cif.hit;
    endproperty
    a_inside: assert property (p_inside)
        else $error("inside window missed");

    property p_outside;
        @(posedge clk_sys) disable iff (srst)
        (cif.lt_lim <= cif.gt_lim) && !differential
        && (cif.word < cif.gt_lim) |-> cif.hit;
    endproperty
    a_outside: assert property (p_outside)
        else $error("outside window missed");

    property p_signed;
        @(posedge clk_sys) disable iff (srst)
        differential && ($signed(cif.lt_lim) > $signed(cif.gt_lim))
        && ($signed(cif.word) > $signed(cif.gt_lim))
        && ($signed(cif.word) < $signed(cif.lt_lim)) |-> cif.hit;
    endproperty
    a_signed: assert property (p_signed)
        else $error("signed window missed");

    property p_format;
        @(posedge clk_sys) disable iff (srst)
        conv_done && !$past(left_justify) && !$past(differential)
        |-> {conversion_result_high, conversion_result_low} < 16'h0400;
    endproperty
    a_format: assert property (p_format)
        else $error("unsigned result out of range");

    property p_lj;
        @(posedge clk_sys) disable iff (srst)
        conv_done && $past(left_justify)
        |-> conversion_result_low[5:0] == 6'h00;
    endproperty
    a_lj: assert property (p_lj)
        else $error("left-justified low bits not zero");

    property p_sext;
        @(posedge clk_sys) disable iff (srst)
        conv_done && $past(differential) && !$past(left_justify)
        |-> conversion_result_high[7:2] == {6{conversion_result_high[1]}};
    endproperty
    a_sext: assert property (p_sext)
        else $error("differential result not sign extended");
endmodule
`default_nettype wire

// file: shared/awc_cmp_if.sv
// Interface carrying a result word and limits to the compare unit
`timescale 1ns/1ps
`default_nettype none
interface awc_cmp_if;
    logic [15:0] word;
    logic [15:0] gt_lim;
    logic [15:0] lt_lim;
    logic is_signed;
    logic hit;
    modport ctrl (output word, output gt_lim, output lt_lim,
        output is_signed, input hit);
    modport cmp (input word, input gt_lim, input lt_lim,
        input is_signed, output hit);
endinterface
`default_nettype wire

// file: shared/awc_pkg.sv
// Shared constants and types for the converter window comparator
package awc_pkg;
    localparam int RES_W = 10;
    localparam int WORD_W = 16;
    localparam int CONV_SAR_CLKS = 10;
    localparam int SAR_CLK_MAX_KHZ = 3000;
    localparam int SYS_CLK_KHZ = 40000;
    // SAR clock divider: ceil so the SAR rate never exceeds its maximum
    localparam int SAR_DIV =
        (SYS_CLK_KHZ + SAR_CLK_MAX_KHZ - 1) / SAR_CLK_MAX_KHZ;
    localparam logic [WORD_W-1:0] LIMIT_RST = 16'h0000;
    localparam logic [WORD_W-1:0] RESULT_RST = 16'h0000;
    localparam int LJ_SHIFT = WORD_W - RES_W;

    typedef enum logic [1:0] {
        AWC_IDLE = 2'b00,
        AWC_CONV = 2'b01,
        AWC_DONE = 2'b10
    } awc_state_e;
endpackage

// file: sim/awc_tb_top.sv
// Self-checking bench for the converter window comparator
`timescale 1ns/1ps
`default_nettype none
module awc_tb_top;
    // One system clock per SAR tick keeps each conversion short
    localparam int SD = 1;
    localparam int CC = 10;
    localparam int LIMIT = 4000;
    logic clk_sys, srst, conv_start, differential, left_justify;
    logic flag_clear, exp_flag;
    logic [9:0] sample_code;
    logic [15:0] gt, lt;
    logic [7:0] res_h, res_l;
    logic conv_busy, conv_done, window_match_flag;
    int bad_count = 0;
    int compares = 0;
    int cycles = 0;

    awc_top #(.SAR_DIV(SD), .CONV_CLKS(CC)) dut (
        .clk_sys(clk_sys),
        .srst(srst),
        .conv_start(conv_start),
        .sample_code(sample_code),
        .differential(differential),
        .left_justify(left_justify),
        .upper_bound_compare_high(gt[15:8]),
        .upper_bound_compare_low(gt[7:0]),
        .lower_bound_compare_high(lt[15:8]),
        .lower_bound_compare_low(lt[7:0]),
        .flag_clear(flag_clear),
        .conversion_result_high(res_h),
        .conversion_result_low(res_l),
        .conv_busy(conv_busy),
        .conv_done(conv_done),
        .window_match_flag(window_match_flag)
    );

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic wrap_up();
        if (bad_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == LIMIT) begin
            bad_count++;
            wrap_up();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] want,
        input string what);
        compares++;
        if (seen !== want) begin
            bad_count++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask

    // Widened to 17 bits so unsigned words never look negative
    function automatic logic win(logic [15:0] w, logic [15:0] g,
        logic [15:0] l, logic d);
        logic signed [16:0] sw, sg, sl;
        sw = d ? {w[15], w} : {1'b0, w};
        sg = d ? {g[15], g} : {1'b0, g};
        sl = d ? {l[15], l} : {1'b0, l};
        return sl > sg ? (sw > sg && sw < sl) : (sw < sg || sw > sl);
    endfunction

    task automatic run(input logic [9:0] code, input logic d,
        input logic lj, input logic [15:0] g, input logic [15:0] l,
        input logic clr);
        logic [15:0] w;
        int n;
        w = lj ? {code, 6'h00} : (d ? {{6{code[9]}}, code} : {6'h00, code});
        exp_flag = win(w, g, l, d) || (exp_flag && !clr);
        sample_code = code;
        differential = d;
        left_justify = lj;
        gt = g;
        lt = l;
        flag_clear = clr;
        conv_start = 1'b1;
        @(negedge clk_sys);
        conv_start = 1'b0;
        flag_clear = 1'b0;
        check(conv_busy, 1'b1, "busy not raised");
        // n counts rising edges after the one that took the start
        n = 0;
        while (conv_done !== 1'b1 && n < 50) begin
            @(negedge clk_sys);
            n++;
        end
        check(n[15:0], 16'(SD * CC + 1), "done latency");
        check(conv_busy, 1'b0, "busy at done");
        check({res_h, res_l}, w, "result word");
        check(window_match_flag, exp_flag, "window flag");
    endtask

    task automatic t_inside();
        run(10'h041, 1'b0, 1'b0, 16'h0040, 16'h0080, 1'b1);
        run(10'h040, 1'b0, 1'b0, 16'h0040, 16'h0080, 1'b1);
        run(10'h07f, 1'b0, 1'b0, 16'h0040, 16'h0080, 1'b1);
        run(10'h080, 1'b0, 1'b0, 16'h0040, 16'h0080, 1'b1);
    endtask

    task automatic t_outside();
        run(10'h03f, 1'b0, 1'b0, 16'h0080, 16'h0040, 1'b1);
        run(10'h040, 1'b0, 1'b0, 16'h0080, 16'h0040, 1'b1);
        run(10'h080, 1'b0, 1'b0, 16'h0080, 16'h0040, 1'b1);
        run(10'h081, 1'b0, 1'b0, 16'h0080, 16'h0040, 1'b1);
        run(10'h050, 1'b0, 1'b0, 16'h0050, 16'h0050, 1'b1);
        run(10'h051, 1'b0, 1'b0, 16'h0050, 16'h0050, 1'b1);
    endtask

    task automatic t_diff();
        run(10'h3ff, 1'b1, 1'b0, 16'hffff, 16'h0040, 1'b1);
        run(10'h000, 1'b1, 1'b0, 16'hffff, 16'h0040, 1'b1);
        run(10'h200, 1'b1, 1'b0, 16'hffff, 16'h0040, 1'b1);
        run(10'h3fe, 1'b1, 1'b0, 16'h0040, 16'hffff, 1'b1);
        run(10'h3ff, 1'b1, 1'b0, 16'h0040, 16'hffff, 1'b1);
        run(10'h041, 1'b1, 1'b0, 16'h0040, 16'hffff, 1'b1);
    endtask

    task automatic t_left();
        run(10'h041, 1'b0, 1'b1, 16'h1000, 16'h2000, 1'b1);
        run(10'h040, 1'b0, 1'b1, 16'h1000, 16'h2000, 1'b1);
        run(10'h3ff, 1'b1, 1'b1, 16'hffc0, 16'h1000, 1'b1);
        run(10'h000, 1'b1, 1'b1, 16'hffc0, 16'h1000, 1'b1);
    endtask

    task automatic t_sticky();
        run(10'h060, 1'b0, 1'b0, 16'h0040, 16'h0080, 1'b1);
        run(10'h010, 1'b0, 1'b0, 16'h0040, 16'h0080, 1'b0);
        run(10'h010, 1'b0, 1'b0, 16'h0040, 16'h0080, 1'b1);
    endtask

    task automatic t_race();
        int n;
        run(10'h010, 1'b0, 1'b0, 16'h0040, 16'h0080, 1'b1);
        // Clear held across the result edge: the new hit must still land
        sample_code = 10'h060;
        flag_clear = 1'b1;
        conv_start = 1'b1;
        @(negedge clk_sys);
        conv_start = 1'b0;
        n = 0;
        while (conv_done !== 1'b1 && n < 50) begin
            @(negedge clk_sys);
            n++;
        end
        check(window_match_flag, 1'b1, "clear beat a new hit");
        flag_clear = 1'b0;
        exp_flag = 1'b1;
    endtask

    initial begin
        srst = 1'b1;
        conv_start = 1'b0;
        sample_code = 10'h000;
        differential = 1'b0;
        left_justify = 1'b0;
        gt = 16'h0000;
        lt = 16'h0000;
        flag_clear = 1'b0;
        exp_flag = 1'b0;
        repeat (10) @(negedge clk_sys);
        srst = 1'b0;
        check(window_match_flag, 1'b0, "flag after reset");
        check(conv_busy, 1'b0, "busy after reset");
        t_inside();
        t_outside();
        t_diff();
        t_left();
        t_sticky();
        t_race();
        wrap_up();
    end
endmodule
`default_nettype wire
